/* hw/ipll_defs.svh */
// constants for the integer-n synthesizer control block
// assumes inclusion by the top module and the bench only
`ifndef IPLL_DEFS_SVH
`define IPLL_DEFS_SVH
`define IPLL_FRAME_BITS  5'd25
`define IPLL_CNT_W       5
`define IPLL_ADDR_RDIV   5'h00
`define IPLL_ADDR_NLO    5'h01
`define IPLL_ADDR_NHI    5'h02
`define IPLL_PSC32_BIT   2
`define IPLL_RDIV_RST    16'h0001
`define IPLL_NLO_RST     16'h0400
`define IPLL_NHI_RST     16'h0004
`define IPLL_DEV_CODE    4'h9
`define IPLL_LOCK_WIN    8'h04
`define IPLL_LOCK_CYC    8'h10
`endif

/* hw/ipll_pkg.sv */
// types shared by the synthesizer control block
// assumes nothing beyond the constants header
package ipll_pkg;
  typedef struct packed {
    logic [3:0]  dev;
    logic [4:0]  addr;
    logic [15:0] data;
  } ipll_frame_s;

  typedef struct packed {
    logic [10:0] rdiv;
    logic        psc32;
    logic [12:0] main_cnt;
    logic [4:0]  swallow;
  } ipll_cfg_s;
endpackage : ipll_pkg

/* hw/ipll_top.sv */
// serial register port, reference and feedback dividers, phase
// detector and lock detector of an integer-n synthesizer.
// assumes all pins are asynchronous to CLK_IN; pin clocks must be
// well below a quarter of CLK_IN so that every edge is seen.
// How it works
// - a frame is exactly 25 bits and makes one register write
// - bits 15:0 data, 20:16 register address, 24:21 device code
// - host drives bus clock, latch strobe and serial data
// - three registers hold reference and two feedback words
// - reference clock divided by 11-bit value feeds phase detector
// - reference ratios 1 to 2047 all supported
// - feedback: 16/17 or 32/33 prescaler, main and swallow counters
// - feedback ratio is prescaler times main plus swallow
// - feedback ratios from prescaler times (prescaler - 1) up to 131071 (16/17) or 262143 (32/33)
// - phase detector acts on rising edges of both inputs only
// - raise on positive phase error, lower on negative
// - lock after enough consecutive narrow raise/lower gaps
// - lock indicator high while locked, low otherwise
// - per-channel shutdown input, high disables the channel
// - high word bits 1:0 are ratio msbs, low word the 16 lsbs
// - serial data sampled on bus clock rising edge
`timescale 1ns/10ps
`include "ipll_defs.svh"

module ipll_top #(
  parameter logic [3:0] DEV_CODE = `IPLL_DEV_CODE, // arbitrary value
  parameter logic [7:0] LOCK_WIN = `IPLL_LOCK_WIN,
  parameter logic [7:0] LOCK_CYC = `IPLL_LOCK_CYC
) (
  input  wire logic CLK_IN,
  input  wire logic SYS_RST_IN,
  input  wire logic BUS_CLK_IN,
  input  wire logic LATCH_STROBE_IN,
  input  wire logic SERIAL_DATA_IN,
  input  wire logic REF_CLK_IN,
  input  wire logic FB_CLK_IN,
  input  wire logic CHANNEL_A_SHUTDOWN_IN,
  input  wire logic CHANNEL_B_SHUTDOWN_IN,
  output logic      PUMP_RAISE_PULSE_OUT,
  output logic      PUMP_LOWER_PULSE_OUT,
  output logic      LOCK_INDICATOR_OUT,
  output logic      CHANNEL_A_ENABLE_OUT,
  output logic      CHANNEL_B_ENABLE_OUT
);

  // ==========================================================
  // pin synchronisers
  logic [6:0] meta_q;
  logic [6:0] sync_q;
  logic [6:0] prev_q;
  logic       sclk_rise;
  logic       strobe_rise;
  logic       ref_rise;
  logic       fb_rise;

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      // strobe idles high: reset to that level so no false rise follows
      meta_q <= 7'h02;
      sync_q <= 7'h02;
      prev_q <= 7'h02;
    end else begin
      meta_q <= {CHANNEL_B_SHUTDOWN_IN, CHANNEL_A_SHUTDOWN_IN, FB_CLK_IN,
                 REF_CLK_IN, SERIAL_DATA_IN, LATCH_STROBE_IN, BUS_CLK_IN};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign sclk_rise = sync_q[0] & ~prev_q[0];
  assign strobe_rise = sync_q[1] & ~prev_q[1];
  assign ref_rise  = sync_q[3] & ~prev_q[3];
  assign fb_rise   = sync_q[4] & ~prev_q[4];

  // ==========================================================
  // serial port and divider registers
  logic [24:0]              shift_q, shift_d;
  logic [`IPLL_CNT_W-1:0]   bits_q, bits_d;
  logic [15:0]              rword_q, rword_d;
  logic [15:0]              nlo_q, nlo_d;
  logic [15:0]              nhi_q, nhi_d;
  logic                     frame_ok;
  ipll_pkg::ipll_frame_s    frame;

  assign frame    = shift_q;
  assign frame_ok = (bits_q == `IPLL_FRAME_BITS)
                    && (frame.dev == DEV_CODE);

  always_comb begin
    shift_d = shift_q;
    bits_d  = bits_q;
    rword_d = rword_q;
    nlo_d   = nlo_q;
    nhi_d   = nhi_q;
    if (strobe_rise) begin
      bits_d = '0;
      if (frame_ok) begin
        case (frame.addr)
          `IPLL_ADDR_RDIV: rword_d = frame.data;
          `IPLL_ADDR_NLO:  nlo_d   = frame.data;
          `IPLL_ADDR_NHI:  nhi_d   = frame.data;
          default: ;
        endcase
      end
    end else if (!sync_q[1] && sclk_rise) begin
      shift_d = {shift_q[23:0], sync_q[2]};
      // saturate so that a long frame never aliases to 25 bits
      if (bits_q != 5'h1f) begin
        bits_d = bits_q + 5'h01;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      shift_q <= '0;
      bits_q  <= '0;
      rword_q <= `IPLL_RDIV_RST;
      nlo_q   <= `IPLL_NLO_RST;
      nhi_q   <= `IPLL_NHI_RST;
    end else begin
      shift_q <= shift_d;
      bits_q  <= bits_d;
      rword_q <= rword_d;
      nlo_q   <= nlo_d;
      nhi_q   <= nhi_d;
    end
  end

  // ==========================================================
  // configuration decode
  ipll_pkg::ipll_cfg_s cfg;
  logic [17:0]         nval;
  logic [10:0]         r_eff;

  assign nval = {nhi_q[1:0], nlo_q};
  // ratio 0 is not meaningful, it behaves as 1
  assign r_eff = (rword_q[10:0] == 11'h000) ? 11'h001 : rword_q[10:0];
  // n = p*m + a is the same ratio as p*(m+1) - (p-a); ratios below p*(p-1)
  // can leave too few main cycles to swallow and are outside the range
  always_comb begin
    cfg.rdiv  = r_eff;
    cfg.psc32 = nhi_q[`IPLL_PSC32_BIT];
    if (cfg.psc32) begin
      cfg.main_cnt = nval[17:5];
      cfg.swallow  = nval[4:0];
    end else begin
      cfg.main_cnt = nval[16:4]; // 13-bit main limits 16/17 mode
      cfg.swallow  = {1'b0, nval[3:0]};
    end
  end

  // ==========================================================
  // reference and feedback dividers
  logic [10:0] rcnt_q, rcnt_d;
  logic [5:0]  pcnt_q, pcnt_d;
  logic [12:0] mcnt_q, mcnt_d;
  logic        ref_p_q, ref_p_d;
  logic        fb_p_q, fb_p_d;
  logic [5:0]  modulus;

  always_comb begin
    modulus = cfg.psc32 ? 6'h20 : 6'h10;
    // first swallow main cycles use p+1; read from the live word, and a write
    // does not restart the counters, so the cycle in progress mixes old and new
    if (mcnt_q < {8'h00, cfg.swallow}) begin
      modulus = modulus + 6'h01;
    end
  end

  always_comb begin
    rcnt_d  = rcnt_q;
    pcnt_d  = pcnt_q;
    mcnt_d  = mcnt_q;
    ref_p_d = 1'b0;
    fb_p_d  = 1'b0;
    if (ref_rise) begin
      if (rcnt_q >= cfg.rdiv - 11'h001) begin
        rcnt_d  = '0;
        ref_p_d = 1'b1;
      end else begin
        rcnt_d = rcnt_q + 11'h001;
      end
    end
    if (fb_rise) begin
      if (pcnt_q >= modulus - 6'h01) begin
        pcnt_d = '0;
        if (mcnt_q >= cfg.main_cnt - 13'h0001) begin
          mcnt_d = '0;
          fb_p_d = 1'b1;
        end else begin
          mcnt_d = mcnt_q + 13'h0001;
        end
      end else begin
        pcnt_d = pcnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      rcnt_q  <= '0;
      pcnt_q  <= '0;
      mcnt_q  <= '0;
      ref_p_q <= 1'b0;
      fb_p_q  <= 1'b0;
    end else begin
      rcnt_q  <= rcnt_d;
      pcnt_q  <= pcnt_d;
      mcnt_q  <= mcnt_d;
      ref_p_q <= ref_p_d;
      fb_p_q  <= fb_p_d;
    end
  end

  // ==========================================================
  // phase detector and lock detector
  logic       up_q, up_d;
  logic       lower_q, lower_d;
  logic [7:0] gap_q, gap_d;
  logic [7:0] lkc_q, lkc_d;
  logic       lock_q, lock_d;
  logic       close;
  logic       narrow;

  assign close  = (ref_p_q & fb_p_q) | (up_q & fb_p_q) | (lower_q & ref_p_q);
  assign narrow = gap_q < LOCK_WIN;

  always_comb begin
    up_d  = up_q;
    lower_d = lower_q;
    gap_d = gap_q;
    lkc_d = lkc_q;
    lock_d = lock_q;
    if (close) begin
      up_d  = 1'b0;
      lower_d = 1'b0;
      gap_d = '0;
      if (narrow) begin
        if (lkc_q != 8'hff) begin
          lkc_d = lkc_q + 8'h01;
        end
        lock_d = lock_q | (lkc_q >= LOCK_CYC - 8'h01);
      end else begin
        lkc_d  = '0;
        lock_d = 1'b0;
      end
    end else begin
      if (ref_p_q) begin
        up_d = 1'b1;
      end
      if (fb_p_q) begin
        lower_d = 1'b1;
      end
      if ((up_q | lower_q) && gap_q != 8'hff) begin
        gap_d = gap_q + 8'h01;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      up_q   <= 1'b0;
      lower_q <= 1'b0;
      gap_q  <= '0;
      lkc_q  <= '0;
      lock_q <= 1'b0;
    end else begin
      up_q   <= up_d;
      lower_q <= lower_d;
      gap_q  <= gap_d;
      lkc_q  <= lkc_d;
      lock_q <= lock_d;
    end
  end

  assign PUMP_RAISE_PULSE_OUT = up_q;
  assign PUMP_LOWER_PULSE_OUT = lower_q;
  assign LOCK_INDICATOR_OUT   = lock_q;
  assign CHANNEL_A_ENABLE_OUT = ~sync_q[5];
  assign CHANNEL_B_ENABLE_OUT = ~sync_q[6];

  // ==========================================================
  // assertions
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  a_frame_write: assert property (strobe_rise && frame_ok
    && frame.addr == `IPLL_ADDR_RDIV |=> rword_q == $past(frame.data))
    else $error("reference word not loaded by valid frame");
  a_foreign_dev: assert property (strobe_rise && frame.dev != DEV_CODE
    |=> $stable(rword_q) && $stable(nlo_q) && $stable(nhi_q))
    else $error("foreign frame changed a register");
  a_short_frame: assert property (strobe_rise && bits_q != 5'd25
    |=> $stable(nlo_q) && $stable(nhi_q))
    else $error("frame of wrong length was accepted");
  a_shift_edge: assert property (!$stable(shift_q)
    |-> $past(sclk_rise) && !$past(sync_q[1]))
    else $error("shift register moved without bus clock rise");
  a_ref_tick: assert property (ref_p_d |-> ref_rise
    && rcnt_q == cfg.rdiv - 11'h001)
    else $error("reference tick at wrong count");
  a_pfd_apart: assert property (!(up_q && lower_q))
    else $error("raise and lower both high");
  a_raise_ref: assert property (ref_p_q && !fb_p_q && !lower_q
    |=> up_q ##1 (up_q || $past(fb_p_q)))
    else $error("raise not driven by reference edge");
  a_lower_fb: assert property (fb_p_q && !ref_p_q && !up_q |=> lower_q)
    else $error("lower not driven by feedback edge");
  a_lock_drop: assert property (close && !narrow |=> !LOCK_INDICATOR_OUT)
    else $error("lock kept after wide gap");
  a_lock_need: assert property ($rose(lock_q)
    |-> $past(lkc_q) >= LOCK_CYC - 8'h01)
    else $error("lock declared too early");
  a_chan_off: assert property (sync_q[5] |-> !CHANNEL_A_ENABLE_OUT)
    else $error("channel a enabled while shut down");

  c_write_nhi: cover property (strobe_rise && frame_ok
    && frame.addr == `IPLL_ADDR_NHI);
  c_fb_tick: cover property (fb_p_q);
  c_locked: cover property ($rose(lock_q));
  c_unlock: cover property ($fell(lock_q));

endmodule : ipll_top

/* bench/ipll_host_model.sv */
// host model that writes frames into the three-wire serial port
// assumes a CLK_IN-rate clock; every pin level is held at least four cycles
`timescale 1ns/10ps

module ipll_host_model (
  input  wire logic clk_in,
  output logic      bus_clk_out,
  output logic      latch_strobe_out,
  output logic      serial_data_out
);
  initial begin
    bus_clk_out      = 1'b0;
    latch_strobe_out = 1'b1;
    serial_data_out  = 1'b0;
  end

  // ==========================================================
  // frame sender
  task automatic hold4;
    repeat (4) @(posedge clk_in);
  endtask : hold4

  // low nbits of the frame go out msb first; only 25 is a real write
  task automatic send(input ipll_pkg::ipll_frame_s f, input int nbits);
    latch_strobe_out <= 1'b0;
    hold4();
    for (int i = nbits - 1; i >= 0; i--) begin
      serial_data_out <= f[i];
      hold4();
      bus_clk_out <= 1'b1;
      hold4();
      bus_clk_out <= 1'b0;
    end
    hold4();
    latch_strobe_out <= 1'b1;
    hold4();
    // released line must not keep showing the last bit
    serial_data_out <= ~serial_data_out;
  endtask : send
endmodule : ipll_host_model

/* bench/test_ipll_top.sv */
// self-checking bench for the synthesizer control block
// assumes the host model for writes; there is no readback, so words
// are checked through the divider counts seen on the pump lines
`timescale 1ns/10ps
`include "ipll_defs.svh"

module test_ipll_top;
  localparam logic [3:0] DV = `IPLL_DEV_CODE;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        rclk = 1'b0;
  logic        fclk = 1'b0;
  logic        sd_a = 1'b1;
  logic        sd_b = 1'b0;
  logic        bclk, latch, sdat, raise, lower, lock, en_a, en_b;
  logic [17:0] cnt;
  int          n_fail = 0;
  int          compares = 0;

  always #12.5 clk = ~clk;

  ipll_host_model u_host (
    .clk_in          (clk),
    .bus_clk_out     (bclk),
    .latch_strobe_out(latch),
    .serial_data_out (sdat)
  );

  // two closes are enough to lock and keep the run short
  ipll_top #(.LOCK_CYC(8'h02)) dut (
    .CLK_IN               (clk),
    .SYS_RST_IN           (rst),
    .BUS_CLK_IN           (bclk),
    .LATCH_STROBE_IN      (latch),
    .SERIAL_DATA_IN       (sdat),
    .REF_CLK_IN           (rclk),
    .FB_CLK_IN            (fclk),
    .CHANNEL_A_SHUTDOWN_IN(sd_a),
    .CHANNEL_B_SHUTDOWN_IN(sd_b),
    .PUMP_RAISE_PULSE_OUT (raise),
    .PUMP_LOWER_PULSE_OUT (lower),
    .LOCK_INDICATOR_OUT   (lock),
    .CHANNEL_A_ENABLE_OUT (en_a),
    .CHANNEL_B_ENABLE_OUT (en_b)
  );

  // ==========================================================
  // helpers
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] dv, input logic [4:0] a,
                    input logic [15:0] d, input int nb);
    u_host.send('{dv, a, d}, nb);
  endtask : wr

  // one pin pulse on each selected clock input, then outputs settle
  task automatic tick(input logic r, input logic f);
    @(posedge clk);
    rclk <= r;
    fclk <= f;
    repeat (4) @(posedge clk);
    rclk <= 1'b0;
    fclk <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask : tick

  // edges on one input until the raise line reaches lvl
  task automatic meas(input logic r, input logic lvl,
                      input logic [17:0] exp);
    cnt = '0;
    do begin
      tick(r, ~r);
      cnt++;
    end while (raise !== lvl && cnt < 18'h00bb8);
    chk(cnt, exp);
    chk({17'h0, lower}, 18'h0);
  endtask : meas

  task automatic results;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  // ==========================================================
  // tests
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk({15'h0, lock, raise, lower}, 18'h0);
    chk({16'h0, en_a, en_b}, 18'h1);
    @(posedge clk);
    sd_a <= 1'b0;
    sd_b <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk({16'h0, en_a, en_b}, 18'h2);
    meas(1'b1, 1'b1, 18'h1);
    meas(1'b0, 1'b0, 18'h400);
    $display("test defaults done");
    wr(DV, `IPLL_ADDR_RDIV, 16'h07ff, 25);
    wr(DV, `IPLL_ADDR_NHI, 16'h0000, 25);
    wr(DV, `IPLL_ADDR_NLO, 16'h0100, 25);
    meas(1'b1, 1'b1, 18'h7ff);
    meas(1'b0, 1'b0, 18'h100);
    $display("test limits done");
    wr(DV, `IPLL_ADDR_RDIV, 16'h0005, 25);
    wr(DV ^ 4'h1, `IPLL_ADDR_RDIV, 16'h0003, 25);
    wr(DV, `IPLL_ADDR_RDIV, 16'h0004, 24);
    wr(DV, 5'h1f, 16'h0007, 25);
    wr(DV, `IPLL_ADDR_NHI, 16'h0004, 25);
    wr(DV, `IPLL_ADDR_NLO, 16'h044c, 25);
    meas(1'b1, 1'b1, 18'h5);
    meas(1'b0, 1'b0, 18'h44c);
    $display("test refused frames done");
    wr(DV, `IPLL_ADDR_RDIV, 16'h0001, 25);
    wr(DV, `IPLL_ADDR_NHI, 16'h0000, 25);
    wr(DV, `IPLL_ADDR_NLO, 16'h0100, 25);
    for (int k = 0; k < 768; k++) begin
      tick(k[7:0] == 8'hff, 1'b1);
    end
    chk({15'h0, lock, raise, lower}, 18'h4);
    tick(1'b1, 1'b0);
    chk({16'h0, raise, lower}, 18'h2);
    meas(1'b0, 1'b0, 18'h100);
    chk({17'h0, lock}, 18'h0);
    $display("test lock done");
    results();
  end

  initial begin
    repeat (80000) @(posedge clk);
    n_fail++;
    results();
  end
endmodule : test_ipll_top
